// *** logic/ilc_cap_word.sv ***
// Purpose: read-only link capability word of the complex_register_block
// Assumes: straps are parameters fixed at build time, not inputs
// Notes: writes are accepted and dropped; other offsets read zero
//
// Overview of operation
// - capability word at 04h, read only
// - speed field indexes supported-speeds bitmap bits
// - reserved speed codes; unimplemented returns zero
// - width field uses fixed lane codes
// - reserved width codes; unimplemented returns zero
// - power management field reports L0s/L1 support
// - bits 24:18 hold supported-speeds bitmap
`timescale 1ns/1ps
module ilc_cap_word
   import ilc_pkg::*;
#(
   parameter logic [3:0] MAX_SPEED = 4'h3,
   parameter logic [5:0] MAX_WIDTH = 6'h10,
   parameter logic [1:0] ASPM_LEVELS = 2'h3,
   parameter logic [6:0] SPEED_VEC = 7'h07
) (
   input wire logic i_clk,
   input wire logic i_nrst,
   input wire logic i_rd,
   input wire logic i_wr,
   input wire logic [11:0] i_addr,
   input wire logic [31:0] i_wdata,
   output logic [31:0] o_rdata,
   output logic o_ack
);

   // codes 1 to 7 index bitmap
   function automatic logic speed_ok(input logic [3:0] c);
      logic ok;
      ok = 1'b0;
      if ((c >= ILC_SPEED_MIN) && (c <= ILC_SPEED_MAX)) begin
         ok = 1'b1;
      end
      return ok;
   endfunction : speed_ok

   function automatic logic width_ok(input logic [5:0] w);
      logic ok;
      ok = 1'b0;
      case (w)
         ILC_W_X1: begin
            ok = 1'b1;
         end
         ILC_W_X2: begin
            ok = 1'b1;
         end
         ILC_W_X4: begin
            ok = 1'b1;
         end
         ILC_W_X8: begin
            ok = 1'b1;
         end
         ILC_W_X12: begin
            ok = 1'b1;
         end
         ILC_W_X16: begin
            ok = 1'b1;
         end
         ILC_W_X32: begin
            ok = 1'b1;
         end
         default: begin
            ok = 1'b0;
         end
      endcase
      return ok;
   endfunction : width_ok

   function automatic logic [3:0] speed_field(input logic [3:0] c);
      logic [3:0] f;
      f = ILC_SPEED_NONE;
      if (speed_ok(c)) begin
         f = c;
      end
      return f;
   endfunction : speed_field

   function automatic logic [5:0] width_field(input logic [5:0] w);
      logic [5:0] f;
      f = ILC_WIDTH_NONE;
      if (width_ok(w)) begin
         f = w;
      end
      return f;
   endfunction : width_field

   function automatic logic [1:0] aspm_field(input logic [1:0] a);
      logic [1:0] f;
      f = ILC_ASPM_NONE;
      case (a)
         ILC_ASPM_NONE: begin
            f = ILC_ASPM_NONE;
         end
         ILC_ASPM_L0S: begin
            f = ILC_ASPM_L0S;
         end
         ILC_ASPM_L1: begin
            f = ILC_ASPM_L1;
         end
         ILC_ASPM_BOTH: begin
            f = ILC_ASPM_BOTH;
         end
         default: begin
            f = ILC_ASPM_NONE;
         end
      endcase
      return f;
   endfunction : aspm_field

   function automatic logic [6:0] vec_field(input logic [6:0] v);
      logic [6:0] f;
      f = 7'h00;
      for (int b = 0; b < 7; b++) begin
         f[b] = v[b] & ILC_VEC_DEFINED[b];
      end
      return f;
   endfunction : vec_field

   function automatic logic cap_hit(input logic [11:0] a);
      return a == ILC_CAP_OFFSET;
   endfunction : cap_hit

   // exit-latency fields are not implemented and read zero
   // unassigned bits forced low
   function automatic logic [31:0] pack_word(
      input logic [3:0] spd,
      input logic [5:0] wid,
      input logic [1:0] pm,
      input logic [6:0] vec
   );
      logic [31:0] w;
      w = 32'h0000_0000;
      w[ILC_SPEED_LSB +: 4] = spd;
      w[ILC_WIDTH_LSB +: 6] = wid;
      w[ILC_ASPM_LSB +: 2] = pm;
      w[ILC_EXIT0_LSB +: 6] = 6'h00;
      w[ILC_VEC_LSB +: 7] = vec;
      return w;
   endfunction : pack_word

   logic [3:0] speed_fld;
   logic [5:0] width_fld;
   logic [1:0] aspm_fld;
   logic [6:0] vec_fld;
   logic [31:0] cap_word;
   logic rd_hit;
   logic any_req;
   logic [31:0] rdata_r;
   logic [31:0] rdata_nxt;
   logic ack_r;
   logic ack_nxt;

   // straps are parameters, so the word is fixed at build time;
   // a bad tie-off reads as not reported rather than as a reserved code
   always_comb begin
      speed_fld = speed_field(MAX_SPEED);
      width_fld = width_field(MAX_WIDTH);
      aspm_fld = aspm_field(ASPM_LEVELS);
      vec_fld = vec_field(SPEED_VEC);
   end

   always_comb begin
      cap_word = pack_word(speed_fld, width_fld, aspm_fld, vec_fld);
   end

   always_comb begin
      rd_hit = i_rd && cap_hit(i_addr);
      any_req = i_rd || i_wr;
   end

   // every access is answered, mapped or not, so software never stalls
   always_comb begin
      ack_nxt = any_req;
   end

   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         ack_r <= 1'b0;
      end else begin
         ack_r <= ack_nxt;
      end
   end

   // data is zero outside the answer cycle, so a stray capture reads nothing
   always_comb begin
      rdata_nxt = 32'h0000_0000;
      if (rd_hit) begin
         rdata_nxt = cap_word;
      end
   end

   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         rdata_r <= ILC_RESET_WORD;
      end else begin
         rdata_r <= rdata_nxt;
      end
   end

   assign o_rdata = rdata_r;
   assign o_ack = ack_r;

endmodule : ilc_cap_word

// *** logic/ilc_pkg.sv ***
// Purpose: constants for the internal link capability word
// Assumes: 32-bit register space, word offsets in bytes
// Notes: field positions and encodings used by the design; the bench hardcodes its own values
package ilc_pkg;
   localparam logic [11:0] ILC_CAP_OFFSET = 12'h004;
   localparam int ILC_SPEED_LSB = 0;
   localparam int ILC_WIDTH_LSB = 4;
   localparam int ILC_ASPM_LSB = 10;
   localparam int ILC_EXIT0_LSB = 12;
   localparam int ILC_VEC_LSB = 18;
   localparam logic [3:0] ILC_SPEED_NONE = 4'h0;
   localparam logic [3:0] ILC_SPEED_MIN = 4'h1;
   localparam logic [3:0] ILC_SPEED_MAX = 4'h7;
   localparam logic [5:0] ILC_WIDTH_NONE = 6'h00;
   localparam logic [5:0] ILC_W_X1 = 6'h01;
   localparam logic [5:0] ILC_W_X2 = 6'h02;
   localparam logic [5:0] ILC_W_X4 = 6'h04;
   localparam logic [5:0] ILC_W_X8 = 6'h08;
   localparam logic [5:0] ILC_W_X12 = 6'h0C;
   localparam logic [5:0] ILC_W_X16 = 6'h10;
   localparam logic [5:0] ILC_W_X32 = 6'h20;
   localparam logic [1:0] ILC_ASPM_NONE = 2'h0;
   localparam logic [1:0] ILC_ASPM_L0S = 2'h1;
   localparam logic [1:0] ILC_ASPM_L1 = 2'h2;
   localparam logic [1:0] ILC_ASPM_BOTH = 2'h3;
   localparam logic [6:0] ILC_VEC_DEFINED = 7'h07;
   localparam logic [31:0] ILC_RESET_WORD = 32'h0000_0000;
endpackage : ilc_pkg

// *** verif/ilc_chk_asserts.sv ***
// Purpose: checks on the capability word
// Assumes: default design parameters
// Notes: fields seen the cycle after a read
`timescale 1ns/1ps
module ilc_chk (
   input wire logic i_clk,
   input wire logic i_nrst,
   input wire logic i_rd,
   input wire logic i_wr,
   input wire logic [11:0] i_addr,
   input wire logic [31:0] o_rdata,
   input wire logic o_ack
);
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_nrst);
   wire rd4 = i_rd && i_addr == 12'h004;
   ack_late_a: assert property (i_rd || i_wr |=> o_ack) else $error("ack missing");
   ack_idle_a: assert property (!(i_rd || i_wr) |=> !o_ack) else $error("ack stray");
   spd_code_a: assert property (rd4 |=> o_rdata[3:0] == 4'h3) else $error("spd");
   spd_rsv_a: assert property (o_rdata[3:0] <= 4'h7) else $error("rsv");
   wid_code_a: assert property (rd4 |=> o_rdata[9:4] == 6'h10) else $error("wid");
   wid_rsv_a: assert property ($onehot0(o_rdata[9:4]) || o_rdata[9:4] == 6'h0C)
      else $error("wrsv");
   pm_code_a: assert property (rd4 |=> o_rdata[11:10] == 2'h3) else $error("pm");
   vec_code_a: assert property (rd4 |=> o_rdata[24:18] == 7'h07) else $error("vec");
   spare_zero_a: assert property (o_rdata[31:25] == 7'h00 && o_rdata[17:12] == 6'h00)
      else $error("spare");
   data_idle_a: assert property (!rd4 |=> o_rdata == 32'h0000_0000)
      else $error("data stray");
   cover property (rd4);
   cover property (i_wr);
   cover property (i_rd && !rd4);
   cover property (i_wr ##1 rd4);
   cover property (rd4 ##1 (i_rd && !rd4));
endmodule : ilc_chk
bind ilc_cap_word ilc_chk chk_u (.i_clk(i_clk), .i_nrst(i_nrst), .i_rd(i_rd), .i_wr(i_wr),
   .i_addr(i_addr), .o_rdata(o_rdata), .o_ack(o_ack));

// *** verif/tb.sv ***
// Purpose: bench for the capability word
// Assumes: default design parameters
// Notes: rows hold request and expected data; ack is expected high after every row
`timescale 1ns/1ps
module tb;
   localparam logic [31:0] WORD = 32'h001C_0D03;
   logic i_clk = 1'b0, i_nrst = 1'b0, i_rd = 1'b0, i_wr = 1'b0, o_ack;
   logic [11:0] i_addr = 12'h000;
   logic [31:0] o_rdata, i_wdata = 32'hFFFF_FFFF;
   int n_errors = 0, samples_checked = 0;
   logic [45:0] rows [6] = '{{2'h2, 12'h004, WORD}, {2'h1, 12'h004, 32'h0000_0000},
      {2'h2, 12'h004, WORD}, {2'h2, 12'h000, 32'h0000_0000},
      {2'h2, 12'h404, 32'h0000_0000}, {2'h1, 12'h008, 32'h0000_0000}};
   ilc_cap_word dut_u (.i_clk(i_clk), .i_nrst(i_nrst), .i_rd(i_rd), .i_wr(i_wr),
      .i_addr(i_addr), .i_wdata(i_wdata), .o_rdata(o_rdata), .o_ack(o_ack));
   initial forever #2 i_clk = ~i_clk;
   task chk(input string nm, input logic [32:0] seen, input logic [32:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         n_errors++;
         $display("wrong value %s exp %h seen %h", nm, exp, seen);
      end
   endtask : chk
   task conclude;
      $display("errors %0d checks %0d", n_errors, samples_checked);
      if (n_errors == 0 && samples_checked > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : conclude
   initial begin
      repeat (6) @(posedge i_clk);
      i_nrst <= 1'b1;
      #1 chk("reset", {o_ack, o_rdata}, 33'h0);
      foreach (rows[k]) begin
         @(posedge i_clk);
         {i_rd, i_wr, i_addr} <= rows[k][45:32];
         @(posedge i_clk);
         {i_rd, i_wr} <= 2'h0;
         #1 chk("row", {o_ack, o_rdata}, {1'b1, rows[k][31:0]});
      end
      @(posedge i_clk);
      #1 chk("idle", {o_ack, o_rdata}, 33'h0);
      @(posedge i_clk);
      {i_rd, i_addr} <= 13'h1004;
      @(posedge i_clk);
      i_addr <= 12'h008;
      #1 chk("b2b first", {o_ack, o_rdata}, {1'b1, WORD});
      @(posedge i_clk);
      {i_rd, i_wr} <= 2'h1;
      i_addr <= 12'h004;
      #1 chk("b2b", {o_ack, o_rdata}, 33'h1_0000_0000);
      @(posedge i_clk);
      {i_rd, i_wr} <= 2'h2;
      #1 chk("b2b write", {o_ack, o_rdata}, 33'h1_0000_0000);
      @(posedge i_clk);
      {i_rd, i_wr} <= 2'h0;
      #1 chk("b2b read", {o_ack, o_rdata}, {1'b1, WORD});
      @(posedge i_clk);
      i_rd <= 1'b1;
      @(posedge i_clk);
      {i_rd, i_nrst} <= 2'h0;
      #1 chk("mid reset", {o_ack, o_rdata}, 33'h0);
      repeat (2) @(posedge i_clk);
      i_nrst <= 1'b1;
      #1 chk("release", {o_ack, o_rdata}, 33'h0);
      @(posedge i_clk);
      i_rd <= 1'b1;
      @(posedge i_clk);
      i_rd <= 1'b0;
      #1 chk("after reset", {o_ack, o_rdata}, {1'b1, WORD});
      conclude;
   end
   initial begin
      #1000;
      n_errors++;
      conclude;
   end
endmodule : tb
